// ### rtl/sdi_init_ctrl.sv
// SDRAM power-on mode programming sequencer with precharge overlap detect

// Summary of operation
// - Area 3 auto-precharge may overlap a following access to another area 0-2.
// - Area 3 auto-precharge may overlap a following access to another area 3 bank.
// - Area 2 auto-precharge may overlap a following access to another area 2 bank.
// - SDRAM auto-precharge may overlap a following ordinary-space access.
// - Mode set drives area chip select with RAS, CAS and write strobe low.
// - Write to base plus X puts X on the address pins at mode set, with A15 also set for the upper base.
// - Mode write must be word sized; its data is ignored.
// - Sequence: precharge-all, eight auto-refresh, then mode register set.
// - Three idle cycles between precharge-all and first refresh.
// - Eight idle cycles after each refresh, regardless of timing settings.
// - Precharge-all closes all banks before any refresh.
module sdi_init_ctrl (
	input  wire logic              i_clk_sys,
	input  wire logic              i_sys_rst,
	input  wire logic              i_wr_req,
	input  wire logic [31:0]       i_wr_addr,
	input  wire logic [1:0]        i_wr_size,
	input  wire logic              i_use_area3,
	input  wire sdi_pkg::sdi_acc_t i_acc,
	output sdi_pkg::sdi_cmd_t      o_cmd,
	output logic                   o_wr_done,
	output logic                   o_wr_err,
	output logic                   o_busy,
	output logic                   o_sdram_hold,
	output logic                   o_overlap
);
	import sdi_pkg::*;

	sdi_state_t              state;
	sdi_state_t              next_state;
	logic [3:0]              idle_cnt;
	logic [3:0]              next_idle_cnt;
	logic [3:0]              ref_cnt;
	logic [3:0]              next_ref_cnt;
	logic [ADDR_PIN_W-1:0]   mode_addr;
	logic [ADDR_PIN_W-1:0]   next_mode_addr;
	logic                    area3;
	logic                    next_area3;
	sdi_cmd_t                next_cmd;
	logic                    next_done;
	logic                    next_err;
	logic                    in_window;
	logic                    hi_base;

	function automatic sdi_cmd_t make_cmd(input logic a3, input logic ras, input logic cas,
		input logic we, input logic [ADDR_PIN_W-1:0] a);
		sdi_cmd_t c;
		c.cs2_n = a3;
		c.cs3_n = !a3;
		c.ras_n = !ras;
		c.cas_n = !cas;
		c.we_n  = !we;
		c.addr  = a;
		return c;
	endfunction : make_cmd

	assign in_window = (i_wr_addr & MODE_WIN_MASK) == MODE_BASE_LO
		|| (i_wr_addr & MODE_WIN_MASK) == MODE_BASE_HI;
	assign hi_base   = (i_wr_addr & MODE_WIN_MASK) == MODE_BASE_HI;

	always_comb begin
		next_state     = state;
		next_idle_cnt  = idle_cnt;
		next_ref_cnt   = ref_cnt;
		next_mode_addr = mode_addr;
		next_area3     = area3;
		next_cmd       = CMD_NOP;
		next_done      = 1'b0;
		next_err       = 1'b0;
		case (state)
			SDI_IDLE: begin
				if (i_wr_req && in_window) begin
					if (i_wr_size != SIZE_WORD) begin
						next_err = 1'b1;
					end else begin
						next_mode_addr = '0;
						next_mode_addr[MODE_VAL_W-1:0] = i_wr_addr[MODE_VAL_W-1:0];
						next_mode_addr[MODE_BANK_BIT]  = hi_base;
						next_area3 = i_use_area3;
						next_state = SDI_PRECHARGE_ALL_CMD;
					end
				end
			end
			SDI_PRECHARGE_ALL_CMD: begin
				// All banks closed: precharge-all with A10 set
				next_cmd = make_cmd(area3, 1'b1, 1'b0, 1'b1, PRECHARGE_ALL_CMD_ADDR);
				next_idle_cnt = PRECHARGE_ALL_CMD_IDLE;
				next_ref_cnt  = '0;
				next_state    = SDI_WAIT;
			end
			SDI_WAIT: begin
				if (idle_cnt > 4'h1) begin
					next_idle_cnt = idle_cnt - 4'h1;
				end else if (ref_cnt == REF_COUNT) begin
					next_state = SDI_MRS;
				end else begin
					next_state = SDI_REF;
				end
			end
			SDI_REF: begin
				next_cmd      = make_cmd(area3, 1'b1, 1'b1, 1'b0, '0);
				next_ref_cnt  = ref_cnt + 4'h1;
				next_idle_cnt = REF_IDLE;
				next_state    = SDI_WAIT;
			end
			SDI_MRS: begin
				next_cmd   = make_cmd(area3, 1'b1, 1'b1, 1'b1, mode_addr);
				next_done  = 1'b1;
				next_state = SDI_IDLE;
			end
			default: begin
				next_state = SDI_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state        <= SDI_IDLE;
			idle_cnt     <= '0;
			ref_cnt      <= '0;
			mode_addr    <= '0;
			area3        <= 1'b0;
			o_cmd        <= CMD_NOP;
			o_wr_done    <= 1'b0;
			o_wr_err     <= 1'b0;
			o_busy       <= 1'b0;
			o_sdram_hold <= 1'b0;
		end else begin
			state        <= next_state;
			idle_cnt     <= next_idle_cnt;
			ref_cnt      <= next_ref_cnt;
			mode_addr    <= next_mode_addr;
			area3        <= next_area3;
			o_cmd        <= next_cmd;
			o_wr_done    <= next_done;
			o_wr_err     <= next_err;
			o_busy       <= next_state != SDI_IDLE;
			o_sdram_hold <= next_state != SDI_IDLE;
		end
	end

	sdi_overlap u_overlap (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_acc     (i_acc),
		.o_overlap (o_overlap)
	);

	sequence s_precharge_all_cmd;
		!o_cmd.ras_n && o_cmd.cas_n && !o_cmd.we_n;
	endsequence
	sequence s_ref;
		!o_cmd.ras_n && !o_cmd.cas_n && o_cmd.we_n;
	endsequence
	sequence s_mrs;
		!o_cmd.ras_n && !o_cmd.cas_n && !o_cmd.we_n;
	endsequence

	precharge_all_cmd_gap_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_precharge_all_cmd |=> o_cmd.ras_n [*3] ##1 s_ref)
		else $error("precharge-all not followed by refresh after three idle cycles");
	ref_gap_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_ref |=> o_cmd.ras_n [*8] ##1 (s_ref or s_mrs))
		else $error("refresh gap is not eight idle cycles");
	mrs_done_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_mrs |-> o_wr_done)
		else $error("mode set without write completion");
	done_mrs_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_wr_done |-> s_mrs and $past(o_cmd.ras_n))
		else $error("completion without mode set");
	seq_len_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_precharge_all_cmd |-> ##76 s_mrs)
		else $error("mode set not at end of full sequence");
	cs_one_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!o_cmd.ras_n |-> (o_cmd.cs2_n != o_cmd.cs3_n))
		else $error("command without exactly one chip select");
	size_err_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_wr_err |-> !o_busy)
		else $error("non-word mode write started the sequence");
	hold_busy_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_precharge_all_cmd |-> o_sdram_hold [*8])
		else $error("SDRAM accesses not held off during init");
	mrs_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_mrs |-> o_cmd.addr[14:12] == 3'h0)
		else $error("mode address carries stray bits");
endmodule : sdi_init_ctrl

// ### inc/sdi_pkg.sv
// Package: constants and carriers for the SDRAM init and precharge overlap block
package sdi_pkg;
	localparam logic [31:0] MODE_BASE_LO   = 32'hffff0000;
	localparam logic [31:0] MODE_BASE_HI   = 32'hffff8000;
	localparam logic [31:0] MODE_WIN_MASK  = 32'hfffff000;
	localparam logic [11:0] MODE_VAL_MAX   = 12'hfff;
	localparam int          MODE_VAL_W     = 12;
	localparam int          ADDR_PIN_W     = 16;
	localparam int          MODE_BANK_BIT  = 15;
	localparam logic [3:0]  PRECHARGE_ALL_CMD_IDLE      = 4'h3;
	localparam logic [3:0]  REF_IDLE       = 4'h8;
	localparam logic [3:0]  REF_COUNT      = 4'h8;
	localparam logic [15:0] PRECHARGE_ALL_CMD_ADDR      = 16'h0400;
	localparam logic [1:0]  SIZE_WORD      = 2'h1;
	localparam logic [1:0]  AREA0          = 2'h0;
	localparam logic [1:0]  AREA1          = 2'h1;
	localparam logic [1:0]  AREA2          = 2'h2;
	localparam logic [1:0]  AREA3          = 2'h3;

	typedef enum logic [4:0] {
		SDI_IDLE = 5'b00001,
		SDI_PRECHARGE_ALL_CMD = 5'b00010,
		SDI_WAIT = 5'b00100,
		SDI_REF  = 5'b01000,
		SDI_MRS  = 5'b10000
	} sdi_state_t;

	// SDRAM command pins, active low
	typedef struct packed {
		logic cs2_n;
		logic cs3_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [ADDR_PIN_W-1:0] addr;
	} sdi_cmd_t;

	// Description of one bus access
	typedef struct packed {
		logic       valid;
		logic [1:0] area;
		logic       sdram;
		logic       auto_pre;
		logic [1:0] bank;
	} sdi_acc_t;

	localparam sdi_cmd_t CMD_NOP = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
endpackage : sdi_pkg

// ### rtl/sdi_overlap.sv
// Decides whether a pending auto-precharge may overlap the next access
module sdi_overlap (
	input  wire logic           i_clk_sys,
	input  wire logic           i_sys_rst,
	input  wire sdi_pkg::sdi_acc_t i_acc,
	output logic                o_overlap
);
	import sdi_pkg::*;

	sdi_acc_t prev;
	sdi_acc_t next_prev;
	logic     next_overlap;

	function automatic logic may_overlap(input sdi_acc_t p, input sdi_acc_t n);
		logic sd_area;
		sd_area = p.sdram && p.auto_pre && (p.area == AREA2 || p.area == AREA3);
		if (!sd_area || !n.valid)
			return 1'b0;
		if (!n.sdram)
			return 1'b1;
		if (n.area != p.area)
			return 1'b1;
		return n.bank != p.bank;
	endfunction : may_overlap

	always_comb begin
		next_prev    = i_acc.valid ? i_acc : prev;
		next_overlap = i_acc.valid && may_overlap(prev, i_acc);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			prev      <= '0;
			o_overlap <= 1'b0;
		end else begin
			prev      <= next_prev;
			o_overlap <= next_overlap;
		end
	end
endmodule : sdi_overlap

// ### bench/sdi_sdram_model.sv
// SDRAM partner: decodes commands, counts idle cycles between them
module sdi_sdram_model
	import sdi_pkg::*;
(
	input  wire logic         i_clk_sys,
	input  wire logic         i_sys_rst,
	input  wire sdi_cmd_t     i_cmd,
	output logic [7:0]        o_gap [0:8],
	output logic [3:0]        o_ref_cnt,
	output logic              o_mrs_seen,
	output logic [15:0]       o_mrs_addr,
	output logic [1:0]        o_mrs_cs,
	output logic              o_bad
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       sel;
	logic       precharge_all_cmd;
	logic [7:0] idle;
	logic [2:0] op;
	assign sel = !(i_cmd.cs2_n && i_cmd.cs3_n);
	assign op  = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			{precharge_all_cmd, idle, o_ref_cnt, o_mrs_seen, o_mrs_addr, o_mrs_cs, o_bad} <= '0;
		end else if (!sel || op == 3'h7) begin
			idle <= idle + 8'h01;
		end else begin
			idle <= 8'h00;
			if (op == 3'h2) begin // Banks all closed before refreshes
				{o_ref_cnt, o_mrs_seen} <= '0;
				precharge_all_cmd <= 1'b1;
			end else if (op == 3'h1) begin
				if (!precharge_all_cmd || o_ref_cnt == 4'h8)
					o_bad <= 1'b1;
				o_gap[o_ref_cnt[2:0]] <= idle;
				o_ref_cnt <= o_ref_cnt + 4'h1;
			end else if (op == 3'h0) begin // Mode capture
				if (o_ref_cnt != 4'h8)
					o_bad <= 1'b1;
				o_gap[8] <= idle;
				o_mrs_seen <= 1'b1;
				o_mrs_addr <= i_cmd.addr;
				o_mrs_cs <= {i_cmd.cs2_n, i_cmd.cs3_n};
			end else
				o_bad <= 1'b1;
		end
	end
endmodule : sdi_sdram_model

// ### bench/sdi_init_ctrl_tb.sv
// Testbench for the SDRAM init sequencer and precharge overlap
module sdi_init_ctrl_tb;
	import sdi_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys = 0, i_sys_rst = 1, i_wr_req = 0, i_use_area3 = 0;
	logic [31:0] i_wr_addr = '0;
	logic [1:0] i_wr_size = SIZE_WORD;
	sdi_acc_t i_acc = '0;
	sdi_cmd_t o_cmd;
	logic o_wr_done, o_wr_err, o_busy, o_sdram_hold, o_overlap, m_seen, m_bad;
	logic [7:0] m_gap [0:8];
	logic [3:0] m_refs;
	logic [15:0] m_addr;
	logic [1:0] m_cs;
	int n_errors = 0, n_checks = 0;
	always #25 i_clk_sys = ~i_clk_sys;
	sdi_init_ctrl u_sdi_init_ctrl (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_wr_req(i_wr_req), .i_wr_addr(i_wr_addr), .i_wr_size(i_wr_size),
		.i_use_area3(i_use_area3), .i_acc(i_acc), .o_cmd(o_cmd), .o_wr_done(o_wr_done),
		.o_wr_err(o_wr_err), .o_busy(o_busy), .o_sdram_hold(o_sdram_hold),
		.o_overlap(o_overlap));
	sdi_sdram_model u_sdi_sdram_model (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_cmd(o_cmd), .o_gap(m_gap), .o_ref_cnt(m_refs), .o_mrs_seen(m_seen),
		.o_mrs_addr(m_addr), .o_mrs_cs(m_cs), .o_bad(m_bad));
	task automatic tally_and_finish;
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask : chk
	// Word write into the mode window; poke sends a stray request while busy
	task automatic mode_wr(input logic [31:0] a, input logic ar3, input logic poke);
		logic done;
		done = 0;
		@(posedge i_clk_sys);
		{i_wr_req, i_wr_addr, i_wr_size, i_use_area3} <= {1'b1, a, SIZE_WORD, ar3};
		for (int n = 0; n < 200 && !done; n++) begin
			@(posedge i_clk_sys);
			i_wr_req <= poke && n == 20;
			#1;
			chk(o_sdram_hold === o_busy, "hold differs from busy");
			if (n == 5)
				chk(o_busy === 1'b1, "not busy");
			if (o_wr_done === 1'b1) begin
				done = 1;
				chk({o_cmd.ras_n, o_cmd.cas_n, o_cmd.we_n} === 3'h0, "done off set");
			end
		end
		@(posedge i_clk_sys);
		#1;
		chk(done && m_seen === 1'b1 && m_refs === 4'h8 && m_bad === 1'b0, "sequence");
		chk(m_gap[0] === 8'h3, "idle after precharge-all");
		for (int k = 1; k < 9; k++)
			chk(m_gap[k] === 8'h8, "idle after refresh");
		chk(m_addr === {a[15], 3'h0, a[11:0]}, "mode value");
		chk(m_cs === (ar3 ? 2'b10 : 2'b01), "mode chip select");
		if (poke) begin
			repeat (10) @(posedge i_clk_sys);
			#1;
			chk(o_busy === 1'b0 && m_refs === 4'h8, "request during busy acted on");
		end
	endtask : mode_wr
	task automatic bad_size;
		@(posedge i_clk_sys);
		{i_wr_req, i_wr_addr, i_wr_size} <= {1'b1, 32'hffff0446, 2'h2};
		@(posedge i_clk_sys);
		i_wr_req <= 1'b0;
		#1;
		chk(o_wr_err === 1'b1, "no size error");
		repeat (4) @(posedge i_clk_sys);
		#1;
		chk(o_busy === 1'b0 && o_cmd === CMD_NOP, "odd size acted on");
	endtask : bad_size
	task automatic ovl(input sdi_acc_t a1, input sdi_acc_t a2, input logic exp);
		@(posedge i_clk_sys);
		i_acc <= a1;
		@(posedge i_clk_sys);
		i_acc <= a2;
		@(posedge i_clk_sys);
		i_acc <= '0;
		#1;
		chk(o_overlap === exp, "overlap");
		@(posedge i_clk_sys);
	endtask : ovl
	// One dummy read to every bank once the mode is set
	task automatic bank_reads(input logic [1:0] area);
		for (int b = 0; b < 4; b++) begin
			@(posedge i_clk_sys);
			i_acc <= '{1'b1, area, 1'b1, 1'b0, 2'(b)};
			#1;
			chk(o_overlap === 1'b0, "overlap after plain read");
		end
		@(posedge i_clk_sys);
		i_acc <= '0;
		#1;
		chk(o_overlap === 1'b0, "overlap after last plain read");
	endtask : bank_reads
	initial begin
		repeat (10) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		mode_wr(32'hffff0426, 1'b0, 1'b1);
		bank_reads(AREA2);
		mode_wr(32'hffff88c8, 1'b1, 1'b0);
		bank_reads(AREA3);
		mode_wr(32'hffff0048, 1'b1, 1'b0);
		mode_wr(32'hffff8066, 1'b0, 1'b0);
		bad_size();
		ovl('{1'b1, AREA3, 1'b1, 1'b1, 2'h0}, '{1'b1, AREA2, 1'b1, 1'b0, 2'h0}, 1'b1);
		ovl('{1'b1, AREA3, 1'b1, 1'b1, 2'h0}, '{1'b1, AREA3, 1'b1, 1'b1, 2'h1}, 1'b1);
		ovl('{1'b1, AREA2, 1'b1, 1'b1, 2'h0}, '{1'b1, AREA2, 1'b1, 1'b0, 2'h2}, 1'b1);
		ovl('{1'b1, AREA2, 1'b1, 1'b1, 2'h1}, '{1'b1, AREA1, 1'b0, 1'b0, 2'h0}, 1'b1);
		ovl('{1'b1, AREA3, 1'b1, 1'b1, 2'h0}, '{1'b1, AREA3, 1'b1, 1'b0, 2'h0}, 1'b0);
		ovl('{1'b1, AREA3, 1'b1, 1'b0, 2'h0}, '{1'b1, AREA0, 1'b0, 1'b0, 2'h0}, 1'b0);
		tally_and_finish();
	end
	initial begin
		#(3000 * 50);
		n_errors++;
		tally_and_finish();
	end
endmodule : sdi_init_ctrl_tb
